// File: pkg/fcs_pkg.sv
`default_nettype none
package fcs_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] FCS_OFF_CLKDIV = 8'h00;
  localparam logic [7:0] FCS_OFF_CONFIG = 8'h01;
  localparam logic [7:0] FCS_OFF_PROT   = 8'h02;
  localparam logic [7:0] FCS_OFF_STATUS = 8'h03;
  localparam logic [7:0] FCS_OFF_CMD    = 8'h04;
  // field positions
  localparam int FCS_DIV_LOADED = 7;
  localparam int FCS_DIV_PRE8   = 6;
  localparam int FCS_CFG_COMPLETE_IRQ_ENABLE   = 7;
  localparam int FCS_CFG_BUFFER_EMPTY_IRQ_ENABLE  = 6;
  localparam int FCS_PROT_OPEN  = 2;
  localparam int FCS_PROT_HDIS  = 1;
  localparam int FCS_PROT_LDIS  = 0;
  localparam int FCS_ST_BUFFER_EMPTY_FLAG   = 7;
  localparam int FCS_ST_COMMAND_COMPLETE_FLAG    = 6;
  localparam int FCS_ST_PROTECTION_VIOLATION_FLAG   = 5;
  localparam int FCS_ST_ACCESS_ERROR_FLAG  = 4;
  localparam int FCS_ST_BLANK   = 2;
  // reset values
  localparam logic [6:0] FCS_DIV_RST  = 7'h00;
  localparam logic [7:0] FCS_CFG_RST  = 8'h00;
  localparam logic [2:0] FCS_PROT_RST = 3'h0;
  // command codes
  localparam logic [7:0] FCS_CMD_VERIFY = 8'h05;
  localparam logic [7:0] FCS_CMD_PROG   = 8'h20;
  localparam logic [7:0] FCS_CMD_SECTOR = 8'h40;
  localparam logic [7:0] FCS_CMD_MASS   = 8'h41;
  // address map of the array windows and protected regions
  localparam logic [1:0]  FCS_WIN_PAGED   = 2'h2;
  localparam logic [1:0]  FCS_WIN_NONE    = 2'h0;
  localparam logic [3:0]  FCS_PAGE_HI     = 4'h3;
  localparam logic [15:0] FCS_SECTOR_MASK = 16'hfe00;
  localparam logic [15:0] FCS_LOW_TOP     = 16'h4800;
  localparam logic [15:0] FCS_HIGH_BASE   = 16'hf800;
  // operation lengths: each runs one timing-clock tick more than its count
  localparam logic [15:0] FCS_PROG_TICKS   = 16'h0006;
  localparam logic [15:0] FCS_SECTOR_TICKS = 16'h0020;
  localparam logic [15:0] FCS_MASS_TICKS   = 16'h0040;
  localparam logic [15:0] FCS_VERIFY_TICKS = 16'h0004;
  typedef enum logic [1:0] {FCS_IDLE, FCS_WORD, FCS_CMD} fcs_seq_t;
endpackage : fcs_pkg
`default_nettype wire

// File: tb/fcs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_host_model (
  input  wire logic        clk,
  output logic      [7:0]  reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  output logic             arr_wr,
  output logic      [15:0] arr_addr,
  output logic      [15:0] arr_wdata,
  output logic             arr_byte
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    arr_wr    = 1'b0;
    arr_addr  = 16'h0000;
    arr_wdata = 16'h0000;
    arr_byte  = 1'b0;
  end
  // qualifiers other than reg_addr in wr are inverted once the strobe drops so stale values do not look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic aw(input logic [15:0] a, input logic [15:0] v, input logic b);
    @(posedge clk);
    arr_addr  <= a;
    arr_wdata <= v;
    arr_byte  <= b;
    arr_wr    <= 1'b1;
    @(posedge clk);
    arr_wr    <= 1'b0;
    arr_addr  <= ~a;
    arr_wdata <= ~v;
  endtask : aw
endmodule : fcs_host_model
`default_nettype wire

// File: tb/test_flash_command_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_flash_command_sequencer;
  import fcs_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, exec_cmd, d;
  logic        reg_wr, reg_rd, arr_wr, arr_byte, hv_on, exec_busy, irq_req;
  logic [15:0] arr_addr, arr_wdata, exec_addr, exec_data;
  logic [1:0]  exec_bank;
  logic [7:0]  page = 8'h30;
  logic        um = 1'b0, sec = 1'b0, unt = 1'b0, stp = 1'b0, wt = 1'b0, ers = 1'b0;
  int          err_total = 0, tests_run = 0, cyc = 0, n;
  logic [7:0]  rst_a [5] = '{FCS_OFF_CLKDIV, FCS_OFF_CONFIG, FCS_OFF_PROT, FCS_OFF_STATUS, 8'h10};
  logic [7:0]  rst_v [5] = '{8'h00, FCS_CFG_RST, 8'h00, 8'hc0, 8'h00};
  logic [7:0]  cmds [4] = '{FCS_CMD_VERIFY, FCS_CMD_SECTOR, FCS_CMD_PROG, FCS_CMD_MASS};
  logic [15:0] ea [4] = '{16'h4003, 16'h4002, 16'h4002, 16'h8002};
  always #2.5 clk = ~clk;
  fcs_sequencer uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_wr(arr_wr), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_byte(arr_byte), .page_select_register(page), .user_mode(um),
    .secure(sec), .untrusted_src(unt), .stop_mode(stp), .wait_mode(wt), .array_erased(ers),
    .hv_on(hv_on), .exec_busy(exec_busy), .exec_cmd(exec_cmd), .exec_addr(exec_addr),
    .exec_data(exec_data), .exec_bank(exec_bank), .irq_req(irq_req));
  fcs_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_wr(arr_wr), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_byte(arr_byte));
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    host.rd(FCS_OFF_STATUS, d);
    chk({8'h00, d & m}, {8'h00, e});
  endtask : st
  task automatic clr;
    host.wr(FCS_OFF_STATUS, 8'h30);
  endtask : clr
  task automatic cfg(input logic [7:0] v);
    host.wr(FCS_OFF_CONFIG, v);
  endtask : cfg
  // word, command, launch with a status read in between
  task automatic seq(input logic [15:0] a, input logic [15:0] v, input logic [7:0] c);
    host.aw(a, v, 1'b0);
    host.rd(FCS_OFF_STATUS, d);
    host.wr(FCS_OFF_CMD, c);
    host.wr(FCS_OFF_STATUS, 8'h80);
  endtask : seq
  task automatic wait_busy(input logic b);
    for (n = 0; n < 400 && exec_busy !== b; n++) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, exec_busy}, {15'h0, b});
  endtask : wait_busy
  task automatic irq(input logic [7:0] v, input logic e);
    cfg(v);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, irq_req}, {15'h0, e});
  endtask : irq
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      host.rd(rst_a[i], d);
      chk({8'h00, d}, {8'h00, rst_v[i]});
    end
    host.aw(16'h4002, 16'h0000, 1'b0);
    st(8'h10, 8'h10);
    host.wr(FCS_OFF_STATUS, 8'h00);
    st(8'h10, 8'h10);
    clr();
    st(8'h10, 8'h00);
    host.wr(FCS_OFF_CLKDIV, 8'h01);
    host.rd(FCS_OFF_CLKDIV, d);
    chk({8'h00, d}, 16'h0081);
    host.wr(FCS_OFF_PROT, 8'h07);
    @(posedge clk) ers <= 1'b1;
    // sector erase precedes the program of the same word
    for (int i = 0; i < 4; i++) begin
      seq(16'h7ffe, 16'h5a5a, cmds[i]);
      wait_busy(1'b1);
      chk({8'h00, exec_cmd}, {8'h00, cmds[i]});
      chk({13'h0, exec_bank, hv_on}, 16'h0001);
      if (i == 1) chk(exec_addr, 16'h7e00);
      if (i == 2) chk(exec_addr, 16'h7ffe);
      wait_busy(1'b0);
      st(8'hd4, (i == 0) ? 8'hc4 : 8'hc0);
    end
    @(posedge clk) wt <= 1'b1;
    seq(16'h4200, 16'h1111, FCS_CMD_SECTOR);
    wait_busy(1'b1);
    seq(16'h4004, 16'h2222, FCS_CMD_PROG);
    st(8'h40, 8'h00);
    for (n = 0; n < 400 && exec_addr !== 16'h4004; n++) begin
      @(posedge clk);
      #1;
    end
    chk(exec_data, 16'h2222);
    st(8'h40, 8'h00);
    wait_busy(1'b0);
    st(8'hd0, 8'hc0);
    @(posedge clk) wt <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cfg({7'h00, i == 2});
      @(posedge clk) page <= (i == 3) ? 8'h05 : 8'h30;
      host.aw(ea[i], 16'h0000, i == 1);
      st(8'h10, 8'h10);
      clr();
    end
    cfg(8'h00);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      um  <= 1'b1;
      sec <= (k == 7);
      unt <= (k == 7);
      host.aw(16'h4002, 16'h0000, 1'b0);
      case (k)
        0: host.aw(16'h4004, 16'h0000, 1'b0);
        1: cfg(8'h00);
        4: host.wr(FCS_OFF_STATUS, 8'h00);
        6: host.wr(FCS_OFF_CMD, 8'h33);
        default: begin
          host.wr(FCS_OFF_CMD, FCS_CMD_PROG);
          if (k == 2) host.wr(FCS_OFF_CMD, FCS_CMD_PROG);
          if (k == 3) host.wr(FCS_OFF_PROT, 8'h07);
          if (k == 5) host.wr(FCS_OFF_STATUS, 8'h00);
        end
      endcase
      st(8'h10, 8'h10);
      clr();
    end
    @(posedge clk) sec <= 1'b0;
    unt <= 1'b0;
    // error parked in bank 1 must lock a launch in bank 0
    cfg(8'h01);
    host.aw(16'h4002, 16'h0000, 1'b0);
    cfg(8'h00);
    seq(16'h4002, 16'h0000, FCS_CMD_PROG);
    repeat (10) @(posedge clk);
    #1;
    chk({15'h0, exec_busy}, 16'h0000);
    host.wr(FCS_OFF_STATUS, 8'h00);
    clr();
    cfg(8'h01);
    clr();
    cfg(8'h00);
    st(8'hd0, 8'hc0);
    host.wr(FCS_OFF_PROT, 8'h00);
    seq(16'h4002, 16'h0000, FCS_CMD_PROG);
    st(8'h20, 8'h20);
    clr();
    host.wr(FCS_OFF_PROT, 8'h03);
    seq(16'h4002, 16'h0000, FCS_CMD_MASS);
    st(8'h20, 8'h20);
    clr();
    host.wr(FCS_OFF_PROT, 8'h07);
    seq(16'h4200, 16'h0000, FCS_CMD_SECTOR);
    wait_busy(1'b1);
    seq(16'h4006, 16'h0000, FCS_CMD_PROG);
    @(posedge clk) stp <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0, exec_busy, hv_on}, 16'h0000);
    @(posedge clk) stp <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk({15'h0, exec_busy}, 16'h0000);
    st(8'hd0, 8'hd0);
    clr();
    irq(8'h80, 1'b1);
    irq(8'h00, 1'b0);
    irq(8'h40, 1'b1);
    irq(8'h80, 1'b1);
    seq(16'h4008, 16'h0000, FCS_CMD_PROG);
    wait_busy(1'b1);
    chk({15'h0, irq_req}, 16'h0000);
    wait_busy(1'b0);
    chk({15'h0, irq_req}, 16'h0001);
    summarize();
  end
endmodule : test_flash_command_sequencer
`default_nettype wire

// File: verilog/fcs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_sequencer #(
  parameter int NB = 4
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        arr_wr,
  input  wire logic [15:0] arr_addr,
  input  wire logic [15:0] arr_wdata,
  input  wire logic        arr_byte,
  input  wire logic [7:0]  page_select_register,
  input  wire logic        user_mode,
  input  wire logic        secure,
  input  wire logic        untrusted_src,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        array_erased,
  output logic             hv_on,
  output logic             exec_busy,
  output logic      [7:0]  exec_cmd,
  output logic      [15:0] exec_addr,
  output logic      [15:0] exec_data,
  output logic [$clog2(NB)-1:0] exec_bank,
  output logic             irq_req
);
  import fcs_pkg::*;
  localparam int BW = $clog2(NB);

  function automatic logic cmd_valid(input logic [7:0] c);
    cmd_valid = (c == FCS_CMD_VERIFY) || (c == FCS_CMD_PROG) ||
                (c == FCS_CMD_SECTOR) || (c == FCS_CMD_MASS);
  endfunction : cmd_valid

  function automatic logic [15:0] cmd_ticks(input logic [7:0] c);
    unique case (c)
      FCS_CMD_PROG:   cmd_ticks = FCS_PROG_TICKS;
      FCS_CMD_SECTOR: cmd_ticks = FCS_SECTOR_TICKS;
      FCS_CMD_MASS:   cmd_ticks = FCS_MASS_TICKS;
      default:        cmd_ticks = FCS_VERIFY_TICKS;
    endcase
  endfunction : cmd_ticks

  logic [6:0]    div_reg;
  logic          div_loaded_reg;
  logic          complete_irq_enable_reg;
  logic          buffer_empty_irq_enable_reg;
  logic [BW-1:0] bank_reg;
  logic          ldis_reg;
  logic          hdis_reg;
  logic          popen_reg;
  fcs_seq_t      seq_reg;
  fcs_seq_t      seq_next;
  logic [BW-1:0] seq_bank_reg;
  logic [15:0]   buf_addr_reg;
  logic [15:0]   buf_data_reg;
  logic [7:0]    buf_cmd_reg;
  logic          pend_v_reg;
  logic [7:0]    pend_cmd_reg;
  logic [15:0]   pend_addr_reg;
  logic [15:0]   pend_data_reg;
  logic [BW-1:0] pend_bank_reg;
  logic [15:0]   act_cnt_reg;
  logic          command_complete_flag_reg;
  logic [NB-1:0] access_error_flag_reg;
  logic [NB-1:0] protection_violation_flag_reg;
  logic [NB-1:0] blank_reg;
  logic [2:0]    pre_reg;
  logic [5:0]    tick_cnt_reg;
  logic          tick;
  logic          acc_set;
  logic          pv_set;
  logic          launch;
  logic          take_word;
  logic          take_cmd;
  logic          win_ok;
  logic          page_ok;
  logic          locked;
  logic          act_done;
  logic          act_free;
  logic          stop_abort;
  logic          st_wr;
  logic [BW-1:0] err_bank;
  logic [15:0]   eff_addr;
  logic          prot_hit;

  assign st_wr    = reg_wr && (reg_addr == FCS_OFF_STATUS);
  assign win_ok   = arr_addr[15:14] != FCS_WIN_NONE;
  assign page_ok  = (arr_addr[15:14] == FCS_WIN_PAGED) ?
                    (page_select_register[7:4] == FCS_PAGE_HI &&
                     page_select_register[BW+1:2] == bank_reg) :
                    (bank_reg == '0);
  assign eff_addr = (arr_addr[15:14] == FCS_WIN_PAGED) ?
                    {page_select_register[1:0], arr_addr[13:0]} : arr_addr;
  assign locked   = (|access_error_flag_reg) || (|protection_violation_flag_reg);
  assign err_bank = (seq_reg == FCS_IDLE) ? bank_reg : seq_bank_reg;
  assign act_done = exec_busy && tick && (act_cnt_reg == 16'h0000);
  assign act_free = !exec_busy || act_done;
  // stop kills whatever is in flight, pending included
  assign stop_abort = stop_mode && (exec_busy || pend_v_reg);

  always_comb begin
    if (buf_addr_reg < FCS_LOW_TOP)
      prot_hit = !ldis_reg;
    else if (buf_addr_reg >= FCS_HIGH_BASE)
      prot_hit = !hdis_reg;
    else
      prot_hit = !popen_reg;
  end

  // command state machine; reads never enter it
  always_comb begin
    seq_next  = seq_reg;
    acc_set   = 1'b0;
    pv_set    = 1'b0;
    launch    = 1'b0;
    take_word = 1'b0;
    take_cmd  = 1'b0;
    if (arr_wr && win_ok) begin
      if (seq_reg != FCS_IDLE || !div_loaded_reg || !page_ok || arr_byte ||
          arr_addr[0] || pend_v_reg)
        acc_set = 1'b1;
      else begin
        take_word = 1'b1;
        seq_next  = FCS_WORD;
      end
    end else if (reg_wr && seq_reg == FCS_WORD) begin
      if (reg_addr != FCS_OFF_CMD)
        acc_set = 1'b1;
      else if (user_mode && !cmd_valid(reg_wdata))
        acc_set = 1'b1;
      else if (secure && untrusted_src && reg_wdata != FCS_CMD_MASS &&
               reg_wdata != FCS_CMD_VERIFY)
        acc_set = 1'b1;
      else begin
        take_cmd = 1'b1;
        seq_next = FCS_CMD;
      end
    end else if (reg_wr && seq_reg == FCS_CMD) begin
      if (!st_wr || !reg_wdata[FCS_ST_BUFFER_EMPTY_FLAG])
        acc_set = 1'b1;
      else if (buf_cmd_reg == FCS_CMD_MASS && !(ldis_reg && hdis_reg && popen_reg))
        pv_set = 1'b1;
      else if ((buf_cmd_reg == FCS_CMD_PROG || buf_cmd_reg == FCS_CMD_SECTOR) && prot_hit)
        pv_set = 1'b1;
      else if (!locked && !stop_mode) begin
        launch   = 1'b1;
        seq_next = FCS_IDLE;
      end
    end
    if (acc_set || pv_set)
      seq_next = FCS_IDLE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_reg      <= FCS_IDLE;
      seq_bank_reg <= '0;
      buf_addr_reg <= 16'h0000;
      buf_data_reg <= 16'h0000;
      buf_cmd_reg  <= 8'h00;
    end else begin
      seq_reg <= stop_mode ? FCS_IDLE : seq_next;
      if (take_word) begin
        seq_bank_reg <= bank_reg;
        buf_addr_reg <= eff_addr;
        buf_data_reg <= arr_wdata;
      end
      if (take_cmd)
        buf_cmd_reg <= reg_wdata;
    end
  end

  // software-written configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg        <= FCS_DIV_RST;
      div_loaded_reg <= 1'b0;
      complete_irq_enable_reg       <= FCS_CFG_RST[FCS_CFG_COMPLETE_IRQ_ENABLE];
      buffer_empty_irq_enable_reg      <= FCS_CFG_RST[FCS_CFG_BUFFER_EMPTY_IRQ_ENABLE];
      bank_reg       <= '0;
      ldis_reg       <= FCS_PROT_RST[FCS_PROT_LDIS];
      hdis_reg       <= FCS_PROT_RST[FCS_PROT_HDIS];
      popen_reg      <= FCS_PROT_RST[FCS_PROT_OPEN];
    end else if (reg_wr && seq_reg == FCS_IDLE) begin
      if (reg_addr == FCS_OFF_CLKDIV) begin
        div_reg        <= reg_wdata[6:0];
        div_loaded_reg <= 1'b1;
      end
      if (reg_addr == FCS_OFF_CONFIG) begin
        complete_irq_enable_reg  <= reg_wdata[FCS_CFG_COMPLETE_IRQ_ENABLE];
        buffer_empty_irq_enable_reg <= reg_wdata[FCS_CFG_BUFFER_EMPTY_IRQ_ENABLE];
        bank_reg  <= reg_wdata[BW-1:0];
      end
      if (reg_addr == FCS_OFF_PROT) begin
        ldis_reg  <= reg_wdata[FCS_PROT_LDIS];
        hdis_reg  <= reg_wdata[FCS_PROT_HDIS];
        popen_reg <= reg_wdata[FCS_PROT_OPEN];
      end
    end
  end

  // timing clock: divide by div+1, optionally by 8 more; frozen in stop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg      <= 3'h0;
      tick_cnt_reg <= 6'h00;
    end else if (!stop_mode && div_loaded_reg) begin
      pre_reg <= pre_reg + 3'h1;
      if (!div_reg[FCS_DIV_PRE8] || pre_reg == 3'h7)
        tick_cnt_reg <= tick ? 6'h00 : tick_cnt_reg + 6'h01;
    end
  end
  assign tick = !stop_mode && div_loaded_reg && (tick_cnt_reg == div_reg[5:0]) &&
                (!div_reg[FCS_DIV_PRE8] || pre_reg == 3'h7);

  // two-stage buffer: pending slot feeds the executing slot; wait mode changes nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_v_reg    <= 1'b0;
      pend_cmd_reg  <= 8'h00;
      pend_addr_reg <= 16'h0000;
      pend_data_reg <= 16'h0000;
      pend_bank_reg <= '0;
    end else if (stop_abort) begin
      pend_v_reg <= 1'b0;
    end else if (launch) begin
      pend_v_reg    <= 1'b1;
      pend_cmd_reg  <= buf_cmd_reg;
      pend_bank_reg <= seq_bank_reg;
      pend_addr_reg <= (buf_cmd_reg == FCS_CMD_SECTOR) ?
                       (buf_addr_reg & FCS_SECTOR_MASK) : buf_addr_reg;
      pend_data_reg <= (buf_cmd_reg == FCS_CMD_PROG) ? buf_data_reg : 16'h0000;
    end else if (pend_v_reg && act_free) begin
      pend_v_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exec_busy   <= 1'b0;
      exec_cmd    <= 8'h00;
      exec_addr   <= 16'h0000;
      exec_data   <= 16'h0000;
      exec_bank   <= '0;
      act_cnt_reg <= 16'h0000;
    end else if (stop_abort) begin
      exec_busy <= 1'b0;
    end else if (act_free) begin
      exec_busy <= pend_v_reg;
      if (pend_v_reg) begin
        exec_cmd    <= pend_cmd_reg;
        exec_addr   <= pend_addr_reg;
        exec_data   <= pend_data_reg;
        exec_bank   <= pend_bank_reg;
        act_cnt_reg <= cmd_ticks(pend_cmd_reg);
      end
    end else if (tick) begin
      act_cnt_reg <= act_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      command_complete_flag_reg <= 1'b1;
    else if (launch)
      command_complete_flag_reg <= 1'b0;
    else if (stop_abort)
      command_complete_flag_reg <= 1'b1;
    else if (act_done && !pend_v_reg)
      command_complete_flag_reg <= 1'b1;
  end

  // per-bank sticky flags; a set in the clearing cycle wins
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic clr_sel;
    assign clr_sel = st_wr && (bank_reg == BW'(b));
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        access_error_flag_reg[b] <= 1'b0;
        protection_violation_flag_reg[b]  <= 1'b0;
        blank_reg[b]  <= 1'b0;
      end else begin
        access_error_flag_reg[b] <= (access_error_flag_reg[b] && !(clr_sel && reg_wdata[FCS_ST_ACCESS_ERROR_FLAG])) ||
                         (acc_set && err_bank == BW'(b)) ||
                         (stop_abort && exec_busy && exec_bank == BW'(b)) ||
                         (stop_abort && pend_v_reg && pend_bank_reg == BW'(b));
        protection_violation_flag_reg[b]  <= (protection_violation_flag_reg[b] && !(clr_sel && reg_wdata[FCS_ST_PROTECTION_VIOLATION_FLAG])) ||
                         (pv_set && err_bank == BW'(b));
        if (act_done && exec_cmd == FCS_CMD_VERIFY && exec_bank == BW'(b))
          blank_reg[b] <= array_erased;
        else if (launch && seq_bank_reg == BW'(b))
          blank_reg[b] <= 1'b0;
      end
    end
  end

  // shared buffer, so buffer-empty and complete read alike in every bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hv_on     <= 1'b0;
      irq_req   <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      hv_on   <= exec_busy && !stop_mode;
      irq_req <= (buffer_empty_irq_enable_reg && !pend_v_reg) || (complete_irq_enable_reg && command_complete_flag_reg);
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          FCS_OFF_CLKDIV: reg_rdata <= {div_loaded_reg, div_reg};
          FCS_OFF_CONFIG: reg_rdata <= {complete_irq_enable_reg, buffer_empty_irq_enable_reg, 6'(bank_reg)};
          FCS_OFF_PROT:   reg_rdata <= {5'h00, popen_reg, hdis_reg, ldis_reg};
          FCS_OFF_STATUS: reg_rdata <= {!pend_v_reg, command_complete_flag_reg, protection_violation_flag_reg[bank_reg],
                                        access_error_flag_reg[bank_reg], 1'b0, blank_reg[bank_reg], 2'h0};
          FCS_OFF_CMD:    reg_rdata <= buf_cmd_reg;
          default:        reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  launch_command_complete_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    launch |=> !command_complete_flag_reg && pend_v_reg) else $error("launch did not clear complete");
  command_complete_flag_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(command_complete_flag_reg) |-> !exec_busy && !pend_v_reg) else $error("complete set while busy");
  lock_launch_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(pend_v_reg) |-> !$past(locked)) else $error("launch while locked");
  div_first_a: assert property (@(posedge clk) disable iff (!resetn)
    arr_wr && win_ok && !div_loaded_reg |=> seq_reg == FCS_IDLE && access_error_flag_reg != '0)
    else $error("array write before divider load accepted");
  zero_abort_a: assert property (@(posedge clk) disable iff (!resetn)
    st_wr && !reg_wdata[FCS_ST_BUFFER_EMPTY_FLAG] && seq_reg != FCS_IDLE |=> seq_reg == FCS_IDLE && access_error_flag_reg != '0)
    else $error("zero to buffer-empty did not abort");
  sector_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    exec_busy && exec_cmd == FCS_CMD_SECTOR |-> exec_addr[8:0] == 9'h000) else $error("sector bits kept");
  erase_data_a: assert property (@(posedge clk) disable iff (!resetn)
    exec_busy && exec_cmd != FCS_CMD_PROG |-> exec_data == 16'h0000) else $error("erase data kept");
  stop_abort_a: assert property (@(posedge clk) disable iff (!resetn)
    stop_abort |=> !exec_busy && !pend_v_reg && command_complete_flag_reg ##1 !hv_on) else $error("stop did not abort");
  w1c_error_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(access_error_flag_reg[0]) |-> $past(st_wr) && $past(reg_wdata[FCS_ST_ACCESS_ERROR_FLAG]) && $past(bank_reg) == '0)
    else $error("error flag self-cleared");
  bad_cmd_a: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == FCS_OFF_CMD && seq_reg == FCS_WORD && user_mode && !cmd_valid(reg_wdata)
    |=> seq_reg == FCS_IDLE) else $error("invalid command accepted");
  pipe_cov: cover property (@(posedge clk) disable iff (!resetn) exec_busy && pend_v_reg);
  stop_cov: cover property (@(posedge clk) disable iff (!resetn) stop_abort);
  blank_cov: cover property (@(posedge clk) disable iff (!resetn) $rose(blank_reg[0]));
endmodule : fcs_sequencer
`default_nettype wire
